// File: common/rosc_defs.vh
// Register offsets, field positions, state codes and timing counts for the
// receiver operating state control bank.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef ROSC_DEFS_VH
`define ROSC_DEFS_VH

`define ROSC_ADDR_W 7
`define ROSC_OFF_FUNCTION_ENABLE 7'h46
`define ROSC_OFF_OPERATING_STATE_CONTROL 7'h47
`define ROSC_OFF_RESTART 7'h4f

`define ROSC_BIT_SLEEP_HALT 6
`define ROSC_BIT_TEST_ENTRY 5
`define ROSC_BIT_FAST_SERIAL 2
`define ROSC_FUNCTION_ENABLE_MASK 8'h64
`define ROSC_FUNCTION_ENABLE_RESET 8'h00

`define ROSC_ST_POWER_UP 3'h0
`define ROSC_ST_SLEEP 3'h1
`define ROSC_ST_STANDBY 3'h2
`define ROSC_ST_TUNE 3'h3
`define ROSC_ST_RECEIVE 3'h4
`define ROSC_ST_EEPROM 3'h5

`define ROSC_CMD_EEPROM 5'h01
`define ROSC_CMD_STANDBY 5'h02
`define ROSC_CMD_TUNE 5'h04
`define ROSC_CMD_RECEIVE 5'h08
`define ROSC_CMD_SLEEP 5'h10

`define ROSC_RESTART_KEY 8'hff

`define ROSC_CLK_MHZ 100
`define ROSC_PUP_TIME_US 100
`define ROSC_PUP_CYCLES (`ROSC_PUP_TIME_US * `ROSC_CLK_MHZ)

`endif

// File: tb/receiver_op_state_control_test.sv
// Bench for the operating state control bank.
// Assumes the host model drives all register traffic.
`timescale 1ns/100ps
module receiver_op_state_control_test;
    logic clk = 1'h0, rst_n = 1'h0, por_ok = 1'h0, wr, rd, rd_d = 1'h0, busy;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, v, x;
    logic [7:0] exp_q [$];
    logic [4:0] cmds [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    logic [2:0] sts [5] = '{3'h5, 3'h2, 3'h3, 3'h4, 3'h1};
    int errors = 0, total_checks = 0, n;
    logic [31:0] seed = 32'hdf13;
    initial forever #5 clk = ~clk;
    rosc_top #(.PUP_CYCLES(4)) uut (.sys_clk_in(clk), .rst_n_in(rst_n),
        .por_ok_in(por_ok), .wr_en_in(wr), .rd_en_in(rd), .addr_in(addr),
        .wdata_in(wdata), .rdata_out(rdata), .sleep_timer_halt_out(),
        .factory_test_entry_out(), .fast_serial_enable_out(),
        .state_readback_out(), .restart_busy_out(busy));
    rosc_host #(.WAIT_CYC(40)) host (.sys_clk_in(clk), .wr_en_out(wr),
        .rd_en_out(rd), .addr_out(addr), .wdata_out(wdata));
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check(input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD rdata expected %h seen %h", e, s);
        end
    endtask
    always @(posedge clk) begin
        if (rd_d) check(exp_q.pop_front(), rdata);
        rd_d <= rd;
    end
    task automatic expect_rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        repeat (20) @(negedge clk);
        expect_rd(7'h47, 8'h00);
        por_ok = 1'h1;
        for (n = 0; n < 200 && busy !== 1'h0; n++) @(negedge clk);
        if (n == 200) begin
            errors++;
            $display("BAD busy expected 0 seen %b", busy);
            report_and_stop();
        end
        expect_rd(7'h47, 8'h20);
        foreach (cmds[i]) begin
            host.wr(7'h47, {3'h0, cmds[i]});
            expect_rd(7'h47, {sts[i], 5'h00});
            x = rnd() & 8'h1f;
            if ($onehot(x)) x = x | 8'h03;
            host.wr(7'h47, x);
            expect_rd(7'h47, {sts[i], 5'h00});
            host.wr(7'h4f, rnd() & 8'hfe);
            expect_rd(7'h47, {sts[i], 5'h00});
            v = rnd() & 8'h64;
            host.wr(7'h46, v);
            expect_rd(7'h46, v);
        end
        expect_rd(7'h4f, 8'h00);
        expect_rd(7'h00, 8'h00);
        host.wr(7'h46, 8'h64);
        host.wr(7'h4f, 8'hff);
        expect_rd(7'h47, 8'h20);
        expect_rd(7'h46, 8'h00);
        report_and_stop();
    end
endmodule

// File: tb/rosc_asserts.sv
// Assertions for the operating state control bank.
// Assumes only the ports of rosc_top; bound below.
`timescale 1ns/100ps
module rosc_asserts (
    input wire sys_clk_in, // Clock.
    input wire rst_n_in, // Reset.
    input wire por_ok_in, // Check.
    input wire wr_en_in, // Write.
    input wire rd_en_in, // Read.
    input wire [6:0] addr_in, // Address.
    input wire [7:0] wdata_in, // Data in.
    input wire [7:0] rdata_out, // Data out.
    input wire sleep_timer_halt_out, // Halt.
    input wire factory_test_entry_out, // Test.
    input wire fast_serial_enable_out, // Fast.
    input wire [2:0] state_readback_out, // State.
    input wire restart_busy_out // Busy.
);
    wire cmd = wr_en_in && addr_in == 7'h47 && !restart_busy_out;
    wire rs = wr_en_in && addr_in == 7'h4f;
    wire [2:0] en_w = {wdata_in[6], wdata_in[5], wdata_in[2]};
    // Enable outputs in the same bit order as en_w.
    wire [2:0] en_out = {sleep_timer_halt_out, factory_test_entry_out,
        fast_serial_enable_out};
    wire [2:0] want = wdata_in[4] ? 3'h1 : wdata_in[3] ? 3'h4 :
        wdata_in[2] ? 3'h3 : wdata_in[1] ? 3'h2 : 3'h5;
    logic [2:0] want_q;
    // The target is held because the readback lags the command.
    always @(posedge sys_clk_in) if (cmd) want_q <= want;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_cmd_state: assert property (cmd && $onehot(wdata_in[4:0])
        |-> ##[1:3] state_readback_out == want_q) else $error("no move");
    a_bad_cmd: assert property (cmd && !$onehot(wdata_in[4:0])
        |=> $stable(state_readback_out)[*3]) else $error("bad move");
    a_restart_key: assert property (rs && wdata_in == 8'hff
        |-> ##[1:3] restart_busy_out) else $error("no restart");
    a_restart_other: assert property (rs && !restart_busy_out
        && wdata_in != 8'hff |=> !restart_busy_out[*3]) else $error("bad");
    a_restart_clear: assert property ($rose(restart_busy_out) |->
        {state_readback_out, en_out} == 6'h00) else $error("not cleared");
    a_pup_done: assert property ($fell(restart_busy_out) |->
        ##[0:1] state_readback_out == 3'h1) else $error("not asleep");
    a_por_fail: assert property (!por_ok_in && restart_busy_out |=>
        restart_busy_out && state_readback_out == 3'h0) else $error("left");
    a_enable_bits: assert property (wr_en_in && addr_in == 7'h46
        && !restart_busy_out |-> ##2 en_out == $past(en_w, 2))
        else $error("enable");
    cover property (cmd && $onehot(wdata_in[4:0]));
    cover property ($rose(restart_busy_out));
    cover property (!por_ok_in && restart_busy_out);
endmodule
bind rosc_top rosc_asserts chk (.*);

// File: tb/rosc_host.sv
// Host model driving the register strobes of the bank.
// Assumes strobes are taken on the rising clock edge.
`timescale 1ns/100ps
module rosc_host #(
    parameter int WAIT_CYC = 1000000
) (
    input wire logic sys_clk_in, // Clock.
    output logic wr_en_out = 1'h0, // Write.
    output logic rd_en_out = 1'h0, // Read.
    output logic [6:0] addr_out = 7'h00, // Address.
    output logic [7:0] wdata_out = 8'h00 // Data.
);
    // Released lines show the inverse so a stale value never passes.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        wr_en_out = 1'h1;
        addr_out = a;
        wdata_out = (a == 7'h46) ? d & 8'h64 : d;
        @(negedge sys_clk_in);
        wr_en_out = 1'h0;
        addr_out = ~a;
        wdata_out = ~d;
        repeat (3) @(negedge sys_clk_in);
        if (a == 7'h4f && d == 8'hff) repeat (WAIT_CYC) @(negedge sys_clk_in);
    endtask
    task automatic rd(input logic [6:0] a);
        @(negedge sys_clk_in);
        rd_en_out = 1'h1;
        addr_out = a;
        @(negedge sys_clk_in);
        rd_en_out = 1'h0;
        addr_out = ~a;
        repeat (2) @(negedge sys_clk_in);
    endtask
endmodule

// File: verilog/rosc_top.v
// Operating state control bank: function enables, state machine with
// readback and switching commands, and the software restart.
// Assumes an SPI front end that delivers decoded one-cycle register writes
// and reads synchronous to sys_clk_in.
// Summary of operation
// - Halt bit stops the running sleep timer.
// - Test entry bit enables manufacturing test mode.
// - Fast serial bit raises serial clock limit.
// - Bits 7:5 read back current operating state.
// - Successful power-up sequence settles in sleep.
// - Failed power-on reset stays in power-up.
// - No command enters the power-up state.
// - Codes 00001 eeprom, 10000 sleep.
// - Codes 00010 standby, 00100 tune, 01000 receive.
// - Undefined command codes leave state unchanged.
// - Writing ff to restart register resets device.
// - Other restart values have no effect.
// - Restart acts as reset then power-up, sleep.
`timescale 1ns/100ps
`include "rosc_defs.vh"

module rosc_top #(
    parameter PUP_CYCLES = `ROSC_PUP_CYCLES
) (
    input wire sys_clk_in, // System clock, 100 MHz.
    input wire rst_n_in, // Power-on reset, active low.
    input wire por_ok_in, // Power-on reset check passed.
    input wire wr_en_in, // One-cycle register write strobe.
    input wire rd_en_in, // One-cycle register read strobe.
    input wire [`ROSC_ADDR_W-1:0] addr_in, // Register address.
    input wire [7:0] wdata_in, // Write data.
    output reg [7:0] rdata_out, // Read data, valid cycle after rd_en_in.
    output reg sleep_timer_halt_out, // Stop the sleep timer.
    output reg factory_test_entry_out, // Manufacturing test enable.
    output reg fast_serial_enable_out, // 1 MHz serial clock allowed.
    output reg [2:0] state_readback_out, // Current operating state code.
    output reg restart_busy_out // Restart or power-up in progress.
);

    // One-hot state machine codes.
    localparam S_PUP = 6'b000001;
    localparam S_SLEEP = 6'b000010;
    localparam S_STBY = 6'b000100;
    localparam S_TUNE = 6'b001000;
    localparam S_RX = 6'b010000;
    localparam S_EE = 6'b100000;

    reg rst_meta;
    reg rst_sync;
    reg [7:0] function_enable;
    reg [5:0] state;
    reg [5:0] next_state;
    reg [31:0] pup_count;
    reg soft_restart;
    reg pup_done;

    // Maps a one-hot state to its readback code.
    function [2:0] state_code;
        input [5:0] st;
        begin
            case (st)
                S_PUP: state_code = `ROSC_ST_POWER_UP;
                S_SLEEP: state_code = `ROSC_ST_SLEEP;
                S_STBY: state_code = `ROSC_ST_STANDBY;
                S_TUNE: state_code = `ROSC_ST_TUNE;
                S_RX: state_code = `ROSC_ST_RECEIVE;
                S_EE: state_code = `ROSC_ST_EEPROM;
                default: state_code = `ROSC_ST_POWER_UP;
            endcase
        end
    endfunction

    // Reset synchroniser; the restart pulse joins it so that a software
    // restart clears what power-on reset clears, except the restart pulse itself.
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= ~soft_restart;
            rst_sync <= rst_meta & ~soft_restart;
        end
    end

    wire wr_func = wr_en_in && (addr_in == `ROSC_OFF_FUNCTION_ENABLE);
    wire wr_ctrl = wr_en_in && (addr_in == `ROSC_OFF_OPERATING_STATE_CONTROL);
    wire wr_rst = wr_en_in && (addr_in == `ROSC_OFF_RESTART);

    // The restart register only reacts to the key; the pulse is held off
    // reset so it survives its own effect for one cycle.
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            soft_restart <= 1'b0;
        end else begin
            soft_restart <= wr_rst && (wdata_in == `ROSC_RESTART_KEY);
        end
    end

    always @(posedge sys_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            function_enable <= `ROSC_FUNCTION_ENABLE_RESET;
        end else if (wr_func) begin
            // Reserved bits are kept at zero whatever the host writes.
            function_enable <= wdata_in & `ROSC_FUNCTION_ENABLE_MASK;
        end
    end

    always @(posedge sys_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            pup_count <= 32'h0;
            pup_done <= 1'b0;
        end else if (!pup_done && por_ok_in) begin
            if (pup_count >= PUP_CYCLES - 1) begin
                pup_done <= 1'b1;
            end else begin
                pup_count <= pup_count + 32'h1;
            end
        end
    end

    always @* begin
        next_state = state;
        case (state)
            S_PUP: begin
                // Without a good power-on check the sequence never ends.
                if (pup_done) begin
                    next_state = S_SLEEP;
                end
            end
            default: begin
                if (wr_ctrl) begin
                    case (wdata_in[4:0])
                        `ROSC_CMD_EEPROM: next_state = S_EE;
                        `ROSC_CMD_SLEEP: next_state = S_SLEEP;
                        `ROSC_CMD_STANDBY: next_state = S_STBY;
                        `ROSC_CMD_TUNE: next_state = S_TUNE;
                        `ROSC_CMD_RECEIVE: next_state = S_RX;
                        default: next_state = state;
                    endcase
                end
            end
        endcase
    end

    always @(posedge sys_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= S_PUP;
        end else begin
            state <= next_state;
        end
    end

    always @(posedge sys_clk_in or negedge rst_sync) begin
        if (!rst_sync) begin
            rdata_out <= 8'h00;
            sleep_timer_halt_out <= 1'b0;
            factory_test_entry_out <= 1'b0;
            fast_serial_enable_out <= 1'b0;
            state_readback_out <= `ROSC_ST_POWER_UP;
            restart_busy_out <= 1'b1;
        end else begin
            sleep_timer_halt_out <= function_enable[`ROSC_BIT_SLEEP_HALT];
            factory_test_entry_out <= function_enable[`ROSC_BIT_TEST_ENTRY];
            fast_serial_enable_out <= function_enable[`ROSC_BIT_FAST_SERIAL];
            state_readback_out <= state_code(state);
            restart_busy_out <= (state == S_PUP);
            if (rd_en_in) begin
                case (addr_in)
                    `ROSC_OFF_FUNCTION_ENABLE: rdata_out <= function_enable;
                    // The command field has no storage and reads zero.
                    `ROSC_OFF_OPERATING_STATE_CONTROL: rdata_out <= {state_code(state), 5'h00};
                    default: rdata_out <= 8'h00;
                endcase
            end
        end
    end

endmodule
